// ===== i2c_pkt_pkg.sv
package i2c_pkt_pkg;
  localparam int         CLK_MHZ       = 125;
  localparam int         IO_BUF_BYTES  = 84;
  localparam logic [6:0] BUF_END       = 7'h54;
  localparam logic [6:0] PTR_MAX       = 7'h7f;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int         RW_BIT        = 0;
  localparam logic [7:0] WA_RESET      = 8'h00;
  localparam logic [7:0] WA_SLEEP      = 8'h01;
  localparam logic [7:0] WA_IDLE       = 8'h02;
  localparam logic [7:0] WA_CMD        = 8'h03;
  localparam logic [7:0] PAD_BYTE      = 8'hff;
  localparam logic [7:0] STATUS_LEN    = 8'h04;
  localparam logic [7:0] WAKE_STATUS   = 8'h11;
  // crc of the wake status block; plain default, execution side owns the real crc
  localparam logic [15:0] WAKE_CRC     = 16'h0000;
  // least times, rounded up to whole cycles
  localparam int WAKE_LOW_NS   = 60000;
  localparam int WAKE_HIGH_NS  = 2500000;
  localparam int WAKE_LOW_CYC  = (WAKE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_HIGH_CYC = (WAKE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CNT_W    = 20;

  typedef logic [WAKE_CNT_W-1:0] wake_cnt_t;
  typedef logic [6:0]            ptr_t;
  typedef enum logic [1:0] {OP_EXEC, OP_SLEEP, OP_IDLE} ctl_op_t;
  typedef struct packed {ptr_t idx; logic [7:0] data;} wr_xfer_t;
  typedef struct packed {ctl_op_t op; logic [7:0] len;} ctl_xfer_t;
  typedef struct packed {logic scl; logic sda;} pins_t;
endpackage

// ===== i2c_packet_port_handler.sv
`timescale 1ns/100ps

module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

module i2c_packet_port_handler #(
  parameter int WAKE_LOW_CYC  = i2c_pkt_pkg::WAKE_LOW_CYC,
  parameter int WAKE_HIGH_CYC = i2c_pkt_pkg::WAKE_HIGH_CYC
) (
  // system clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // link clock and bus pins
  input  wire logic       link_clk,
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_bit,
  output logic            sda_oe_n,
  // configured bus address byte
  input  wire logic [7:0] dev_addr,
  // execution side
  output logic            exec_start,
  output logic      [7:0] exec_len,
  input  wire logic       exec_done,
  output logic            busy,
  output logic            sleeping,
  output logic            idling,
  output logic            volatile_clear,
  input  wire logic       buf_we,
  input  wire logic [6:0] buf_addr,
  input  wire logic [7:0] buf_wdata,
  output logic      [7:0] buf_rdata
);
  typedef enum {L_IDLE, L_RX, L_ACK, L_TX, L_TACK} lstate_t;
  typedef enum {K_ADDR, K_WORD, K_DATA} kind_t;
  typedef enum {P_SLEEP, P_IDLE, P_WLO, P_WHI, P_AWAKE, P_BUSY} pstate_t;

  // ------------------------------------------------------------
  // link domain: synchronisers
  // ------------------------------------------------------------
  logic                   lrst_n;
  i2c_pkt_pkg::pins_t     pin_s;
  i2c_pkt_pkg::pins_t     pin_d_r;
  logic [7:0]             addr_s;
  logic [2:0]             lin_s;
  logic                   done_d_r;
  logic                   rs_d_r;
  // clk domain registers read by the link side
  logic                   ready_r;
  logic                   done_tg_r;
  logic                   rs_tg_r;
  logic [7:0]             rs_data_r;

  bit_sync #(.W(1)) u_lrst (.clk(link_clk), .arst_n(arst_n), .d(1'b1), .q(lrst_n));
  bit_sync #(.W(2)) u_pins (.clk(link_clk), .arst_n(lrst_n), .d({scl, sda}), .q(pin_s));
  bit_sync #(.W(8)) u_addr (.clk(link_clk), .arst_n(lrst_n), .d(dev_addr), .q(addr_s));
  bit_sync #(.W(3)) u_lin  (.clk(link_clk), .arst_n(lrst_n),
                            .d({ready_r, done_tg_r, rs_tg_r}), .q(lin_s));

  logic ready_s;
  logic done_ev;
  logic rs_ev;
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;
  assign ready_s  = lin_s[2];
  assign done_ev  = lin_s[1] ^ done_d_r;
  assign rs_ev    = lin_s[0] ^ rs_d_r;
  assign start_c  = pin_s.scl & pin_d_r.scl & pin_d_r.sda & ~pin_s.sda;
  assign stop_c   = pin_s.scl & pin_d_r.scl & ~pin_d_r.sda & pin_s.sda;
  assign scl_rise = pin_s.scl & ~pin_d_r.scl;
  assign scl_fall = ~pin_s.scl & pin_d_r.scl;

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      pin_d_r  <= '1;
      done_d_r <= 1'b0;
      rs_d_r   <= 1'b0;
    end else begin
      pin_d_r  <= pin_s;
      done_d_r <= lin_s[1];
      rs_d_r   <= lin_s[0];
    end
  end

  // ------------------------------------------------------------
  // link domain: byte decisions
  // ------------------------------------------------------------
  lstate_t           lst_r;
  kind_t             kind_r;
  logic [3:0]        bit_cnt_r;
  logic [7:0]        shift_r;
  logic [7:0]        tx_r;
  logic [7:0]        word_r;
  logic [7:0]        want_r;
  logic [7:0]        rd_byte_r;
  i2c_pkt_pkg::ptr_t ptr_r;
  logic              in_prog_r;
  logic              pend_r;
  logic              park_r;
  logic              after_rd_r;
  logic              rd_mode_r;
  logic              mack_r;

  logic              rx_done;
  logic              addr_hit;
  logic              rd_ok;
  logic              data_ok;
  logic              take_addr_w;
  logic              take_addr_r;
  logic              take_word;
  logic              take_data;
  logic              load_tx;
  logic              launch;
  logic              sleep_cmd;
  logic              idle_cmd;
  logic              gate;
  i2c_pkt_pkg::ptr_t wr_idx;
  i2c_pkt_pkg::ptr_t ptr_inc;
  logic              word_ack_r;

  assign rx_done     = (lst_r == L_RX) && scl_fall && (bit_cnt_r == i2c_pkt_pkg::BITS_PER_BYTE);
  assign addr_hit    = shift_r[7:1] == addr_s[7:1];
  assign rd_ok       = ready_s && !pend_r && !in_prog_r && !park_r;
  assign wr_idx      = after_rd_r ? '0 : ptr_r;
  assign data_ok     = (word_r == i2c_pkt_pkg::WA_CMD) && !pend_r
                       && (wr_idx < i2c_pkt_pkg::BUF_END)
                       && ((wr_idx == '0) || ({1'b0, wr_idx} < want_r));
  assign take_addr_w = rx_done && (kind_r == K_ADDR) && addr_hit && !shift_r[i2c_pkt_pkg::RW_BIT];
  assign take_addr_r = rx_done && (kind_r == K_ADDR) && addr_hit && shift_r[i2c_pkt_pkg::RW_BIT]
                       && rd_ok;
  assign take_word   = rx_done && (kind_r == K_WORD);
  assign take_data   = rx_done && (kind_r == K_DATA) && data_ok;
  assign load_tx     = scl_fall && !gate
                       && (((lst_r == L_ACK) && rd_mode_r) || ((lst_r == L_TACK) && mack_r));
  assign ptr_inc     = (ptr_r == i2c_pkt_pkg::PTR_MAX) ? ptr_r : ptr_r + 7'h01;
  assign launch      = stop_c && in_prog_r && ({1'b0, ptr_r} == want_r);
  // sleep and idle wait for the end of the word address ack, else the ack is cut short
  assign sleep_cmd   = word_ack_r && scl_fall && (lst_r == L_ACK) && !gate
                       && (word_r == i2c_pkt_pkg::WA_SLEEP);
  assign idle_cmd    = word_ack_r && scl_fall && (lst_r == L_ACK) && !gate
                       && (word_r == i2c_pkt_pkg::WA_IDLE);
  assign gate        = park_r || !ready_s;

  // ------------------------------------------------------------
  // link domain: bit level state machine
  // ------------------------------------------------------------
  // the open-drain pin only ever pulls low, so sda_bit stays zero
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      sda_bit <= 1'b0;
    end else begin
      sda_bit <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lst_r     <= L_IDLE;
      kind_r    <= K_ADDR;
      bit_cnt_r <= '0;
      shift_r   <= '0;
      tx_r      <= '0;
      rd_mode_r <= 1'b0;
      mack_r    <= 1'b0;
      sda_oe_n  <= 1'b1;
    end else if (gate) begin
      lst_r    <= L_IDLE;
      sda_oe_n <= 1'b1;
    end else if (start_c) begin
      lst_r     <= L_RX;
      kind_r    <= K_ADDR;
      bit_cnt_r <= '0;
      sda_oe_n  <= 1'b1;
    end else if (stop_c) begin
      lst_r    <= L_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      unique case (lst_r)
        L_IDLE: begin
        end
        L_RX: begin
          if (scl_rise && (bit_cnt_r != i2c_pkt_pkg::BITS_PER_BYTE)) begin
            shift_r   <= {shift_r[6:0], pin_s.sda};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (rx_done) begin
            // a foreign address or a refused read leaves the bus alone until the next start
            if ((kind_r == K_ADDR) && !(take_addr_w || take_addr_r)) begin
              lst_r <= L_IDLE;
            end else begin
              lst_r     <= L_ACK;
              sda_oe_n  <= !(take_addr_w || take_addr_r || take_word || take_data);
              rd_mode_r <= take_addr_r;
              kind_r    <= (kind_r == K_ADDR) ? K_WORD : K_DATA;
            end
          end
        end
        L_ACK, L_TACK: begin
          if (scl_rise && (lst_r == L_TACK)) begin
            mack_r <= !pin_s.sda;
          end else if (load_tx) begin
            lst_r     <= L_TX;
            tx_r      <= {rd_byte_r[6:0], 1'b0};
            sda_oe_n  <= rd_byte_r[7];
            bit_cnt_r <= 4'h1;
            mack_r    <= 1'b0;
          end else if (scl_fall) begin
            lst_r     <= (lst_r == L_ACK) ? L_RX : L_IDLE;
            bit_cnt_r <= '0;
            sda_oe_n  <= 1'b1;
          end
        end
        L_TX: begin
          if (scl_fall && (bit_cnt_r == i2c_pkt_pkg::BITS_PER_BYTE)) begin
            lst_r    <= L_TACK;
            sda_oe_n <= 1'b1;
          end else if (scl_fall) begin
            sda_oe_n  <= tx_r[7];
            tx_r      <= {tx_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // link domain: address counter and block progress
  // ------------------------------------------------------------
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ptr_r      <= '0;
      want_r     <= '0;
      word_r     <= '0;
      in_prog_r  <= 1'b0;
      after_rd_r <= 1'b0;
    end else if (sleep_cmd || idle_cmd || done_ev) begin
      ptr_r      <= '0;
      want_r     <= '0;
      in_prog_r  <= 1'b0;
      after_rd_r <= 1'b0;
    end else if (launch) begin
      in_prog_r <= 1'b0;
    end else if (take_word) begin
      word_r <= shift_r;
      if (shift_r == i2c_pkt_pkg::WA_RESET) begin
        ptr_r      <= '0;
        want_r     <= '0;
        in_prog_r  <= 1'b0;
        after_rd_r <= 1'b0;
      end
    end else if (take_data) begin
      ptr_r      <= wr_idx + 7'h01;
      after_rd_r <= 1'b0;
      if (wr_idx == '0) begin
        want_r    <= shift_r;
        in_prog_r <= 1'b1;
      end
    end else if (load_tx) begin
      // the counter moves when a byte goes out, so a prefetch after a nack is not lost
      ptr_r      <= ptr_inc;
      after_rd_r <= 1'b1;
    end else if (take_addr_r) begin
      after_rd_r <= 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      pend_r     <= 1'b0;
      park_r     <= 1'b0;
      word_ack_r <= 1'b0;
    end else begin
      if (take_word) begin
        word_ack_r <= 1'b1;
      end else if (scl_fall || start_c || stop_c || gate) begin
        word_ack_r <= 1'b0;
      end
      // pend covers the few cycles before busy arrives through the synchroniser
      if (launch) begin
        pend_r <= 1'b1;
      end else if (done_ev) begin
        pend_r <= 1'b0;
      end
      if (sleep_cmd || idle_cmd) begin
        park_r <= 1'b1;
      end else if (!ready_s) begin
        park_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // link domain: events towards the system clock
  // ------------------------------------------------------------
  logic                   wr_tg_r;
  logic                   ctl_tg_r;
  logic                   rq_tg_r;
  i2c_pkt_pkg::wr_xfer_t  wr_pay_r;
  i2c_pkt_pkg::ctl_xfer_t ctl_pay_r;
  i2c_pkt_pkg::ptr_t      rq_idx_r;

  // payloads stay put for at least one bit time, far longer than the crossing takes
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      wr_tg_r   <= 1'b0;
      ctl_tg_r  <= 1'b0;
      rq_tg_r   <= 1'b0;
      wr_pay_r  <= '0;
      ctl_pay_r <= '0;
      rq_idx_r  <= '0;
    end else begin
      if (take_data) begin
        wr_tg_r  <= ~wr_tg_r;
        wr_pay_r <= '{idx: wr_idx, data: shift_r};
      end
      if (launch) begin
        ctl_tg_r  <= ~ctl_tg_r;
        ctl_pay_r <= '{op: i2c_pkt_pkg::OP_EXEC, len: want_r};
      end else if (sleep_cmd || idle_cmd) begin
        ctl_tg_r  <= ~ctl_tg_r;
        ctl_pay_r <= '{op: sleep_cmd ? i2c_pkt_pkg::OP_SLEEP : i2c_pkt_pkg::OP_IDLE, len: '0};
      end
      // the next byte is fetched while the current one shifts out
      if (take_addr_r) begin
        rq_tg_r  <= ~rq_tg_r;
        rq_idx_r <= ptr_r;
      end else if (load_tx) begin
        rq_tg_r  <= ~rq_tg_r;
        rq_idx_r <= ptr_inc;
      end
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      rd_byte_r <= i2c_pkt_pkg::PAD_BYTE;
    end else if (rs_ev) begin
      rd_byte_r <= rs_data_r;
    end
  end

  // ------------------------------------------------------------
  // system domain: power state and execution handshake
  // ------------------------------------------------------------
  logic [2:0]             cin_s;
  logic [2:0]             cin_d_r;
  logic                   sda_c;
  logic                   wr_ev;
  logic                   ctl_ev;
  logic                   rq_ev;
  pstate_t                pst_r;
  i2c_pkt_pkg::wake_cnt_t wake_cnt_r;
  logic                   from_sleep_r;
  logic                   load_stat_r;
  logic [7:0]             io_buf [i2c_pkt_pkg::IO_BUF_BYTES];

  bit_sync #(.W(3)) u_cin (.clk(clk), .arst_n(arst_n),
                           .d({wr_tg_r, ctl_tg_r, rq_tg_r}), .q(cin_s));
  bit_sync #(.W(1)) u_sdac (.clk(clk), .arst_n(arst_n), .d(sda), .q(sda_c));

  assign wr_ev  = cin_s[2] ^ cin_d_r[2];
  assign ctl_ev = cin_s[1] ^ cin_d_r[1];
  assign rq_ev  = cin_s[0] ^ cin_d_r[0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cin_d_r        <= '0;
      pst_r          <= P_SLEEP;
      wake_cnt_r     <= '0;
      from_sleep_r   <= 1'b1;
      load_stat_r    <= 1'b0;
      exec_start     <= 1'b0;
      exec_len       <= '0;
      volatile_clear <= 1'b0;
      done_tg_r      <= 1'b0;
    end else begin
      cin_d_r        <= cin_s;
      exec_start     <= 1'b0;
      volatile_clear <= 1'b0;
      load_stat_r    <= 1'b0;
      unique case (pst_r)
        P_SLEEP, P_IDLE: begin
          if (!sda_c) begin
            pst_r      <= P_WLO;
            wake_cnt_r <= '0;
          end
        end
        P_WLO: begin
          if (sda_c) begin
            pst_r <= from_sleep_r ? P_SLEEP : P_IDLE;
          end else if (wake_cnt_r == i2c_pkt_pkg::wake_cnt_t'(WAKE_LOW_CYC - 1)) begin
            pst_r      <= P_WHI;
            wake_cnt_r <= '0;
          end else begin
            wake_cnt_r <= wake_cnt_r + 1'b1;
          end
        end
        P_WHI: begin
          // the delay runs from the rising edge of the wake pulse
          if (!sda_c) begin
            wake_cnt_r <= '0;
          end else if (wake_cnt_r == i2c_pkt_pkg::wake_cnt_t'(WAKE_HIGH_CYC - 1)) begin
            pst_r       <= P_AWAKE;
            load_stat_r <= from_sleep_r;
          end else begin
            wake_cnt_r <= wake_cnt_r + 1'b1;
          end
        end
        P_AWAKE: begin
          if (ctl_ev) begin
            unique case (ctl_pay_r.op)
              i2c_pkt_pkg::OP_EXEC: begin
                pst_r      <= P_BUSY;
                exec_start <= 1'b1;
                exec_len   <= ctl_pay_r.len;
              end
              i2c_pkt_pkg::OP_SLEEP: begin
                pst_r          <= P_SLEEP;
                from_sleep_r   <= 1'b1;
                volatile_clear <= 1'b1;
              end
              default: begin
                pst_r        <= P_IDLE;
                from_sleep_r <= 1'b0;
              end
            endcase
          end
        end
        P_BUSY: begin
          if (exec_done) begin
            pst_r     <= P_AWAKE;
            done_tg_r <= ~done_tg_r;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_r  <= 1'b0;
      busy     <= 1'b0;
      sleeping <= 1'b1;
      idling   <= 1'b0;
    end else begin
      ready_r  <= (pst_r == P_AWAKE);
      busy     <= (pst_r == P_BUSY);
      sleeping <= (pst_r != P_AWAKE) && (pst_r != P_BUSY) && from_sleep_r;
      idling   <= (pst_r != P_AWAKE) && (pst_r != P_BUSY) && !from_sleep_r;
    end
  end

  // ------------------------------------------------------------
  // system domain: i/o buffer
  // ------------------------------------------------------------
  // byte 0 always holds the count of the block that a read returns
  always_ff @(posedge clk) begin
    if (load_stat_r) begin
      io_buf[0] <= i2c_pkt_pkg::STATUS_LEN;
      io_buf[1] <= i2c_pkt_pkg::WAKE_STATUS;
      io_buf[2] <= i2c_pkt_pkg::WAKE_CRC[7:0];
      io_buf[3] <= i2c_pkt_pkg::WAKE_CRC[15:8];
    end else if (wr_ev) begin
      io_buf[wr_pay_r.idx] <= wr_pay_r.data;
    end else if (buf_we && (buf_addr < i2c_pkt_pkg::BUF_END)) begin
      io_buf[buf_addr] <= buf_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs_tg_r   <= 1'b0;
      rs_data_r <= i2c_pkt_pkg::PAD_BYTE;
      buf_rdata <= '0;
    end else begin
      buf_rdata <= (buf_addr < i2c_pkt_pkg::BUF_END) ? io_buf[buf_addr] : '0;
      if (rq_ev) begin
        rs_tg_r <= ~rs_tg_r;
        if ((rq_idx_r < i2c_pkt_pkg::BUF_END) && ({1'b0, rq_idx_r} < io_buf[0])) begin
          rs_data_r <= io_buf[rq_idx_r];
        end else begin
          rs_data_r <= i2c_pkt_pkg::PAD_BYTE;
        end
      end
    end
  end
endmodule

// ===== i2c_port_checker_assertions.sv
`timescale 1ns/100ps
module i2c_port_checker (
  // system clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // bus pin drive
  input wire logic       sda_bit,
  input wire logic       sda_oe_n,
  // execution side
  input wire logic       exec_start,
  input wire logic [7:0] exec_len,
  input wire logic       exec_done,
  input wire logic       busy,
  input wire logic       sleeping,
  input wire logic       idling,
  input wire logic       volatile_clear,
  input wire logic [6:0] buf_addr,
  input wire logic [7:0] buf_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  start_sets_busy_a: assert property (exec_start |=> busy && !exec_start)
    else $error("busy did not follow the block hand-over");
  start_when_awake_a: assert property (exec_start |-> !busy && !sleeping && !idling)
    else $error("block handed over while not awake");
  done_ends_busy_a: assert property (busy && exec_done |-> ##2 !busy)
    else $error("busy stayed after execution finished");
  count_held_a: assert property (busy |-> $stable(exec_len))
    else $error("block count moved during execution");
  asleep_quiet_a: assert property (sleeping [*8] |-> sda_oe_n)
    else $error("data line driven while asleep");
  idle_quiet_a: assert property (idling [*8] |-> sda_oe_n)
    else $error("data line driven while idle");
  busy_quiet_a: assert property (busy [*8] |-> sda_oe_n)
    else $error("data line driven while executing");
  clear_sleeps_a: assert property (volatile_clear |-> ##[0:2] sleeping)
    else $error("state cleared without sleeping");
  open_drain_a: assert property (sda_bit == 1'b0)
    else $error("data line driven high");
  pad_read_a: assert property (buf_addr >= 7'h54 |=> buf_rdata == 8'h00)
    else $error("read past buffer end not zero");
  cover property (exec_start);
  cover property (volatile_clear);
  cover property ($rose(idling));
endmodule

bind i2c_packet_port_handler i2c_port_checker u_chk (.clk, .arst_n, .sda_bit, .sda_oe_n,
  .exec_start, .exec_len, .exec_done, .busy, .sleeping, .idling, .volatile_clear, .buf_addr,
  .buf_rdata);

// ===== i2c_host_model.sv
`timescale 1ns/100ps
module i2c_host_model (
  // pacing clock and drive seen from the target
  input wire logic clk,
  input wire logic sda_oe_n,
  // bus wires
  output logic     scl,
  output logic     sda
);
  logic pull_low;
  // pull-up wins unless someone pulls low
  assign sda = (pull_low || !sda_oe_n) ? 1'b0 : 1'b1;
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // sda moves only while scl is low; sampled mid-high
  task automatic bit_io(input logic b, output logic got);
    hold(12);
    pull_low = !b;
    hold(13);
    scl = 1'b1;
    hold(12);
    got = sda;
    hold(13);
    scl = 1'b0;
  endtask
  task automatic start();
    pull_low = 1'b0;
    hold(12);
    scl = 1'b1;
    hold(12);
    pull_low = 1'b1;
    hold(12);
    scl = 1'b0;
  endtask
  task automatic stop();
    hold(12);
    pull_low = 1'b1;
    hold(13);
    scl = 1'b1;
    hold(12);
    pull_low = 1'b0;
    hold(25);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(b[i], g);
    bit_io(1'b1, g);
    ack = !g;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!more, g);
  endtask
  task automatic wake();
    pull_low = 1'b1;
    hold(400);
    pull_low = 1'b0;
    hold(80);
  endtask
endmodule

// ===== tb_i2c_packet_port_handler.sv
`timescale 1ns/100ps
module tb_i2c_packet_port_handler;
  localparam logic [7:0] ADDR = 8'hc8;
  logic       clk = 1'b0, link_clk = 1'b0, arst_n = 1'b0, exec_done = 1'b0, buf_we = 1'b0;
  logic [6:0] buf_addr = 7'h00;
  logic [7:0] buf_wdata = 8'h00, exec_len, buf_rdata;
  logic       scl, sda, sda_bit, sda_oe_n, exec_start, busy, sleeping, idling, volatile_clear;
  int         n_mismatch = 0, total_checks = 0;
  always #4 clk = ~clk;
  initial #1.7 forever #6 link_clk = ~link_clk;
  // wake low must outlast the longest low of ordinary traffic (two zero bits, 100 cycles)
  i2c_packet_port_handler #(.WAKE_LOW_CYC(300), .WAKE_HIGH_CYC(20)) u_dut (.clk, .arst_n,
    .link_clk, .scl, .sda, .sda_bit, .sda_oe_n, .dev_addr(ADDR), .exec_start, .exec_len,
    .exec_done, .busy, .sleeping, .idling, .volatile_clear, .buf_we, .buf_addr, .buf_wdata,
    .buf_rdata);
  i2c_host_model u_host (.clk, .sda_oe_n, .scl, .sda);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr_pkt(input logic [7:0] wa, input logic [7:0] q[$], output logic [7:0] acks);
    logic a;
    acks = 8'h00;
    u_host.start();
    u_host.wr_byte(ADDR & 8'hfe, a);
    chk("write address ack", 8'h01, {7'h0, a});
    u_host.wr_byte(wa, a);
    chk("word address ack", 8'h01, {7'h0, a});
    foreach (q[i]) begin
      u_host.wr_byte(q[i], a);
      acks[i] = a;
    end
    u_host.stop();
  endtask
  task automatic rd_pkt(input logic ack_exp, input logic [7:0] q[$]);
    logic       a;
    logic [7:0] b;
    u_host.start();
    u_host.wr_byte(ADDR | 8'h01, a);
    chk("read address ack", {7'h0, ack_exp}, {7'h0, a});
    if (a === 1'b1) begin
      foreach (q[i]) begin
        u_host.rd_byte(i < q.size() - 1, b);
        chk("read byte", q[i], b);
      end
    end
    u_host.stop();
  endtask
  task automatic t_foreign();
    logic a;
    u_host.start();
    u_host.wr_byte(ADDR ^ 8'h80, a);
    chk("foreign address ack", 8'h00, {7'h0, a});
    u_host.stop();
  endtask
  task automatic t_cmd();
    logic [7:0] acks;
    logic [7:0] res [4] = '{8'h04, 8'h5a, 8'h12, 8'h34};
    wr_pkt(8'h03, '{8'h05, 8'ha1, 8'ha2}, acks);
    chk("first part acks", 8'h07, acks);
    rd_pkt(1'b0, '{});
    wr_pkt(8'h03, '{8'ha3, 8'ha4, 8'ha5}, acks);
    chk("second part acks", 8'h03, acks);
    chk("busy after stop", 8'h01, {7'h0, busy});
    chk("block count", 8'h05, exec_len);
    rd_pkt(1'b0, '{});
    for (int i = 0; i < 4; i++) begin
      buf_we = 1'b1;
      buf_addr = 7'(i);
      buf_wdata = res[i];
      @(negedge clk);
    end
    buf_we = 1'b0;
    exec_done = 1'b1;
    @(negedge clk);
    exec_done = 1'b0;
    repeat (4) @(negedge clk);
    chk("busy after done", 8'h00, {7'h0, busy});
    buf_addr = 7'h01;
    repeat (2) @(negedge clk);
    chk("buffer read", 8'h5a, buf_rdata);
    buf_addr = 7'h54;
    repeat (2) @(negedge clk);
    chk("buffer read past end", 8'h00, buf_rdata);
    rd_pkt(1'b1, '{8'h04, 8'h5a, 8'h12, 8'h34, 8'hff});
    wr_pkt(8'h00, '{}, acks);
    rd_pkt(1'b1, '{8'h04});
  endtask
  task automatic t_idle();
    logic [7:0] acks;
    wr_pkt(8'h02, '{}, acks);
    chk("idling", 8'h01, {7'h0, idling});
    rd_pkt(1'b0, '{});
    u_host.wake();
    chk("idling after wake", 8'h00, {7'h0, idling});
    wr_pkt(8'h00, '{}, acks);
    rd_pkt(1'b1, '{8'h04, 8'h5a});
  endtask
  task automatic t_sleep();
    logic [7:0] acks;
    wr_pkt(8'h01, '{}, acks);
    chk("sleeping", 8'h01, {7'h0, sleeping});
    rd_pkt(1'b0, '{});
    u_host.wake();
    chk("sleeping after wake", 8'h00, {7'h0, sleeping});
    rd_pkt(1'b1, '{8'h04, 8'h11, 8'h00, 8'h00});
  endtask
  initial begin
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    u_host.wake();
    rd_pkt(1'b1, '{8'h04, 8'h11, 8'h00, 8'h00, 8'hff});
    t_foreign();
    t_cmd();
    t_idle();
    t_sleep();
    wrap_up();
  end
  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end
endmodule
